//--- include/nfc_cfg.svh
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH

// bus widths
`define NFC_AW 21
`define NFC_DW 16

// timing in ns and derived cycle counts
`define NFC_CLK_NS 25
`define NFC_T_ACC_NS 70
`define NFC_T_WP_NS 50
`define NFC_T_WH_NS 25
`define NFC_CEIL_CYC(t) (((t) + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_ACC_CYC `NFC_CEIL_CYC(`NFC_T_ACC_NS)
`define NFC_WP_CYC `NFC_CEIL_CYC(`NFC_T_WP_NS)
`define NFC_WH_CYC `NFC_CEIL_CYC(`NFC_T_WH_NS)

// command codes
`define NFC_C_READ 8'hFF
`define NFC_C_ERASE 8'h20
`define NFC_C_CONFIRM 8'hD0
`define NFC_C_PROG 8'h40
`define NFC_C_DUAL 8'hE0
`define NFC_C_SUSP 8'hB0
`define NFC_C_RESUME 8'hD0
`define NFC_C_IDENT 8'h90
`define NFC_C_QUERY 8'h98
`define NFC_C_LOCK 8'h60
`define NFC_C_SOFT 8'h01
`define NFC_C_HARD 8'h2F
`define NFC_C_UNLOCK 8'hD0
`define NFC_C_RSTAT 8'h70
`define NFC_C_CLR 8'h50
`define NFC_C_OTP 8'hC0
`define NFC_CMD_HI 8'h00

// otp area
`define NFC_OTP_LOCK_ADDR 21'h000080
`define NFC_OTP_LOCK_DATA 16'hFFFD
`define NFC_OTP_FIRST 8'h81
`define NFC_OTP_USER 8'h85
`define NFC_OTP_LAST 8'h88
`define NFC_LOCK_BIT 1

// device status bits
`define NFC_SR_READY 7
`define NFC_SR_PFAIL 4
`define NFC_SR_VPP 3
`define NFC_SR_LOCK 1

// sector map
`define NFC_BOOT_END 21'h008000
`define NFC_SMALL_MASK 21'h1FF000
`define NFC_BIG_MASK 21'h1F8000

// software register offsets
`define NFC_REG_CMD 8'h00
`define NFC_REG_ADDR 8'h04
`define NFC_REG_WD0 8'h08
`define NFC_REG_WD1 8'h0C
`define NFC_REG_RDATA 8'h10
`define NFC_REG_STATUS 8'h14
`define NFC_REG_CFG 8'h18
`define NFC_REG_IRQ_ST 8'h1C
`define NFC_REG_IRQ_MASK 8'h20

// interrupt bits
`define NFC_IRQ_W 3
`define NFC_IRQ_DONE 0
`define NFC_IRQ_ERR 1
`define NFC_IRQ_REF 2

// reset values
`define NFC_PINS_IDLE {1'b1, 1'b1, 1'b1, 21'h000000, 16'h0000, 1'b0}

`endif

//--- include/nfc_pkg.sv
`include "nfc_cfg.svh"

package nfc_pkg;

	typedef enum logic [4:0] {
		OP_READ_ARRAY,
		OP_READ_WORD,
		OP_READ_STATUS,
		OP_CLEAR_STATUS,
		OP_WORD_PROG,
		OP_DUAL_PROG,
		OP_ERASE,
		OP_SUSPEND,
		OP_RESUME,
		OP_IDENT,
		OP_QUERY,
		OP_SOFTLOCK,
		OP_HARDLOCK,
		OP_UNLOCK,
		OP_OTP_PROG,
		OP_OTP_LOCK,
		OP_OTP_QUERY
	} nfc_op_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WE,
		ST_WREC,
		ST_OE,
		ST_REC
	} nfc_state_t;

	typedef struct packed {
		logic               ce_n;
		logic               oe_n;
		logic               we_n;
		logic [`NFC_AW-1:0] addr;
		logic [`NFC_DW-1:0] dq_out;
		logic               dq_oe;
	} nfc_pins_t;

	typedef struct packed {
		logic               rd;
		logic [`NFC_AW-1:0] addr;
		logic [`NFC_DW-1:0] data;
		logic               last;
		logic               poll;
	} nfc_cyc_t;

endpackage

//--- src/nfc_ctrl.sv
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "nfc_cfg.svh"

module nfc_ctrl #(
	parameter int ACC_CYC = `NFC_ACC_CYC,
	parameter int WP_CYC  = `NFC_WP_CYC,
	parameter int WH_CYC  = `NFC_WH_CYC
) (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	// software register port
	input  wire logic [7:0]        sw_addr,
	input  wire logic [31:0]       sw_wdata,
	input  wire logic              sw_wr,
	input  wire logic              sw_rd,
	output logic [31:0]            sw_rdata,
	output logic                   irq,
	// flash pins
	output nfc_pkg::nfc_pins_t     flash_o,
	input  wire logic [`NFC_DW-1:0] flash_dq_in
);

	function automatic logic [`NFC_DW-1:0] cmd_f(logic [7:0] code);
		cmd_f = {`NFC_CMD_HI, code};
	endfunction

	function automatic logic [`NFC_AW-1:0] sector_f(logic [`NFC_AW-1:0] a);
		if (a < `NFC_BOOT_END) begin
			sector_f = a & `NFC_SMALL_MASK;
		end else begin
			sector_f = a & `NFC_BIG_MASK;
		end
	endfunction

	function automatic nfc_pkg::nfc_cyc_t step_f(
		nfc_pkg::nfc_op_t   op,
		logic [1:0]         step,
		logic [`NFC_AW-1:0] a,
		logic [`NFC_DW-1:0] d0,
		logic [`NFC_DW-1:0] d1
	);
		nfc_pkg::nfc_cyc_t c;
		logic              first;
		c = '0;
		first = (step == 2'h0);
		c.addr = '0;
		case (op)
			nfc_pkg::OP_READ_ARRAY: begin
				c.data = cmd_f(`NFC_C_READ);
				c.last = 1'b1;
			end
			nfc_pkg::OP_READ_WORD: begin
				c.rd = 1'b1;
				c.addr = a;
				c.last = 1'b1;
			end
			nfc_pkg::OP_READ_STATUS: begin
				c.rd = !first;
				c.data = cmd_f(`NFC_C_RSTAT);
				c.last = !first;
			end
			nfc_pkg::OP_CLEAR_STATUS: begin
				c.data = cmd_f(`NFC_C_CLR);
				c.last = 1'b1;
			end
			nfc_pkg::OP_WORD_PROG: begin
				c.data = first ? cmd_f(`NFC_C_PROG) : d0;
				c.addr = first ? '0 : a;
				c.poll = !first;
			end
			nfc_pkg::OP_DUAL_PROG: begin
				c.data = first ? cmd_f(`NFC_C_DUAL) :
					(step == 2'h1) ? d0 : d1;
				c.addr = first ? '0 : {a[`NFC_AW-1:1], step[1]};
				c.poll = (step == 2'h2);
			end
			nfc_pkg::OP_ERASE: begin
				c.data = cmd_f(first ? `NFC_C_ERASE : `NFC_C_CONFIRM);
				c.addr = first ? '0 : sector_f(a);
				c.poll = !first;
			end
			nfc_pkg::OP_SUSPEND: begin
				c.data = cmd_f(`NFC_C_SUSP);
				c.last = 1'b1;
			end
			nfc_pkg::OP_RESUME: begin
				c.data = cmd_f(`NFC_C_RESUME);
				c.last = 1'b1;
			end
			nfc_pkg::OP_IDENT: begin
				c.data = cmd_f(`NFC_C_IDENT);
				c.last = 1'b1;
			end
			nfc_pkg::OP_QUERY: begin
				c.data = cmd_f(`NFC_C_QUERY);
				c.last = 1'b1;
			end
			nfc_pkg::OP_SOFTLOCK, nfc_pkg::OP_HARDLOCK,
			nfc_pkg::OP_UNLOCK: begin
				c.addr = first ? '0 : sector_f(a);
				c.last = !first;
				if (first) begin
					c.data = cmd_f(`NFC_C_LOCK);
				end else if (op == nfc_pkg::OP_SOFTLOCK) begin
					c.data = cmd_f(`NFC_C_SOFT);
				end else if (op == nfc_pkg::OP_HARDLOCK) begin
					c.data = cmd_f(`NFC_C_HARD);
				end else begin
					c.data = cmd_f(`NFC_C_UNLOCK);
				end
			end
			nfc_pkg::OP_OTP_PROG: begin
				c.data = first ? cmd_f(`NFC_C_OTP) : d0;
				c.addr = first ? '0 : a;
				c.poll = !first;
			end
			nfc_pkg::OP_OTP_LOCK: begin
				c.data = first ? cmd_f(`NFC_C_OTP) : `NFC_OTP_LOCK_DATA;
				c.addr = first ? '0 : `NFC_OTP_LOCK_ADDR;
				c.poll = !first;
			end
			nfc_pkg::OP_OTP_QUERY: begin
				c.rd = !first;
				c.data = cmd_f(`NFC_C_IDENT);
				c.addr = first ? '0 : `NFC_OTP_LOCK_ADDR;
				c.last = !first;
			end
			default: begin
				c.last = 1'b1;
			end
		endcase
		step_f = c;
	endfunction

	nfc_pkg::nfc_state_t     state_q, state_d;
	nfc_pkg::nfc_op_t        op_q, op_d, op_in;
	nfc_pkg::nfc_pins_t      pins_q, pins_d;
	nfc_pkg::nfc_cyc_t       cc, lc;
	logic [3:0]              cnt_q, cnt_d;
	logic [1:0]              step_q, step_d;
	logic                    polling_q, polling_d;
	logic                    exiting_q, exiting_d;
	logic [`NFC_AW-1:0]      addr_q, addr_d;
	logic [`NFC_DW-1:0]      wd0_q, wd0_d;
	logic [`NFC_DW-1:0]      wd1_q, wd1_d;
	logic [`NFC_DW-1:0]      rd_q, rd_d;
	logic [7:0]              dev_st_q, dev_st_d;
	logic                    err_lock_q, err_lock_d;
	logic                    err_vpp_q, err_vpp_d;
	logic                    err_prog_q, err_prog_d;
	logic                    otp_locked_q, otp_locked_d;
	logic                    dual_en_q, dual_en_d;
	logic [`NFC_IRQ_W-1:0]   irq_st_q, irq_st_d;
	logic [`NFC_IRQ_W-1:0]   mask_q, mask_d;
	logic [`NFC_IRQ_W-1:0]   ev;
	logic [31:0]             sw_rdata_q, sw_rdata_d;
	logic                    irq_q, irq_d;
	logic                    busy, launch, complete, refuse, prog_op;
	logic                    s1, s3, s4;

	assign busy = (state_q != nfc_pkg::ST_IDLE);
	assign s1 = rd_q[`NFC_SR_LOCK];
	assign s3 = rd_q[`NFC_SR_VPP];
	assign s4 = rd_q[`NFC_SR_PFAIL];

	always_comb begin
		state_d = state_q;
		op_d = op_q;
		pins_d = pins_q;
		cnt_d = cnt_q;
		step_d = step_q;
		polling_d = polling_q;
		exiting_d = exiting_q;
		addr_d = addr_q;
		wd0_d = wd0_q;
		wd1_d = wd1_q;
		rd_d = rd_q;
		dev_st_d = dev_st_q;
		err_lock_d = err_lock_q;
		err_vpp_d = err_vpp_q;
		err_prog_d = err_prog_q;
		otp_locked_d = otp_locked_q;
		dual_en_d = dual_en_q;
		mask_d = mask_q;
		ev = '0;
		launch = 1'b0;
		complete = 1'b0;
		lc = '0;
		op_in = nfc_pkg::nfc_op_t'(sw_wdata[4:0]);
		cc = step_f(op_q, step_q, addr_q, wd0_q, wd1_q);
		prog_op = (op_in == nfc_pkg::OP_WORD_PROG) ||
			(op_in == nfc_pkg::OP_DUAL_PROG) ||
			(op_in == nfc_pkg::OP_ERASE) ||
			(op_in == nfc_pkg::OP_OTP_PROG) ||
			(op_in == nfc_pkg::OP_OTP_LOCK);
		refuse = prog_op && (err_vpp_q || err_lock_q || err_prog_q);
		if (op_in == nfc_pkg::OP_OTP_PROG) begin
			refuse = refuse || (addr_q[`NFC_AW-1:8] != '0) ||
				(addr_q[7:0] < `NFC_OTP_FIRST) ||
				(addr_q[7:0] > `NFC_OTP_LAST) ||
				(otp_locked_q && (addr_q[7:0] >= `NFC_OTP_USER));
		end
		if (op_in == nfc_pkg::OP_DUAL_PROG) begin
			refuse = refuse || !dual_en_q;
		end
		if (op_in > nfc_pkg::OP_OTP_QUERY) begin
			refuse = 1'b1;
		end
		if (sw_wr) begin
			case (sw_addr)
				`NFC_REG_CMD: begin
					if (busy || refuse) begin
						ev[`NFC_IRQ_REF] = 1'b1;
					end else begin
						op_d = op_in;
						step_d = 2'h0;
						polling_d = 1'b0;
						exiting_d = 1'b0;
						launch = 1'b1;
						lc = step_f(op_in, 2'h0, addr_q, wd0_q, wd1_q);
					end
				end
				`NFC_REG_ADDR: addr_d = sw_wdata[`NFC_AW-1:0];
				`NFC_REG_WD0: wd0_d = sw_wdata[`NFC_DW-1:0];
				`NFC_REG_WD1: wd1_d = sw_wdata[`NFC_DW-1:0];
				`NFC_REG_CFG: dual_en_d = sw_wdata[0];
				`NFC_REG_IRQ_MASK: mask_d = sw_wdata[`NFC_IRQ_W-1:0];
				default: begin
				end
			endcase
		end
		case (state_q)
			nfc_pkg::ST_WE: begin
				if (cnt_q == 4'h0) begin
					pins_d.we_n = 1'b1;
					pins_d.ce_n = 1'b1;
					cnt_d = 4'(WH_CYC - 1);
					state_d = nfc_pkg::ST_WREC;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			nfc_pkg::ST_WREC: begin
				if (cnt_q == 4'h0) begin
					pins_d.dq_oe = 1'b0;
					complete = 1'b1;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			nfc_pkg::ST_OE: begin
				if (cnt_q == 4'h0) begin
					rd_d = flash_dq_in;
					pins_d.ce_n = 1'b1;
					pins_d.oe_n = 1'b1;
					state_d = nfc_pkg::ST_REC;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			nfc_pkg::ST_REC: begin
				complete = 1'b1;
			end
			default: begin
			end
		endcase
		if (complete) begin
			state_d = nfc_pkg::ST_IDLE;
			if (exiting_q) begin
				ev[`NFC_IRQ_DONE] = 1'b1;
			end else if (polling_q) begin
				if (rd_q[`NFC_SR_READY]) begin
					dev_st_d = rd_q[7:0];
					err_vpp_d = err_vpp_q || (!s1 && s3 && s4);
					err_prog_d = err_prog_q || (!s1 && !s3 && s4);
					err_lock_d = err_lock_q || (s1 && !s3 && s4);
					ev[`NFC_IRQ_ERR] = s1 || s3 || s4;
					exiting_d = 1'b1;
					launch = 1'b1;
					lc.data = cmd_f(`NFC_C_READ);
				end else begin
					launch = 1'b1;
					lc.rd = 1'b1;
				end
			end else if (cc.last) begin
				ev[`NFC_IRQ_DONE] = 1'b1;
				if (op_q == nfc_pkg::OP_READ_STATUS) begin
					dev_st_d = rd_q[7:0];
				end
				if (op_q == nfc_pkg::OP_OTP_QUERY) begin
					otp_locked_d = !rd_q[`NFC_LOCK_BIT];
				end
				if (op_q == nfc_pkg::OP_CLEAR_STATUS) begin
					err_vpp_d = 1'b0;
					err_prog_d = 1'b0;
					err_lock_d = 1'b0;
				end
			end else if (cc.poll) begin
				polling_d = 1'b1;
				launch = 1'b1;
				lc.rd = 1'b1;
			end else begin
				step_d = step_q + 2'h1;
				launch = 1'b1;
				lc = step_f(op_q, step_q + 2'h1, addr_q, wd0_q, wd1_q);
			end
		end
		if (launch) begin
			pins_d.ce_n = 1'b0;
			pins_d.addr = lc.addr;
			pins_d.dq_out = lc.data;
			pins_d.dq_oe = !lc.rd;
			pins_d.oe_n = !lc.rd;
			pins_d.we_n = lc.rd;
			cnt_d = lc.rd ? 4'(ACC_CYC - 1) : 4'(WP_CYC - 1);
			state_d = lc.rd ? nfc_pkg::ST_OE : nfc_pkg::ST_WE;
		end
		irq_st_d = irq_st_q;
		if (sw_wr && (sw_addr == `NFC_REG_IRQ_ST)) begin
			irq_st_d = irq_st_q & ~sw_wdata[`NFC_IRQ_W-1:0];
		end
		irq_st_d = irq_st_d | ev;
		irq_d = |(irq_st_d & mask_d);
		sw_rdata_d = '0;
		if (sw_rd) begin
			case (sw_addr)
				`NFC_REG_CMD: sw_rdata_d = {27'h0000000, op_q};
				`NFC_REG_ADDR: sw_rdata_d = {11'h000, addr_q};
				`NFC_REG_WD0: sw_rdata_d = {16'h0000, wd0_q};
				`NFC_REG_WD1: sw_rdata_d = {16'h0000, wd1_q};
				`NFC_REG_RDATA: sw_rdata_d = {16'h0000, rd_q};
				`NFC_REG_STATUS: sw_rdata_d = {19'h00000, otp_locked_q,
					err_prog_q, err_vpp_q, err_lock_q, busy, dev_st_q};
				`NFC_REG_CFG: sw_rdata_d = {31'h00000000, dual_en_q};
				`NFC_REG_IRQ_ST: sw_rdata_d = {29'h00000000, irq_st_q};
				`NFC_REG_IRQ_MASK: sw_rdata_d = {29'h00000000, mask_q};
				default: sw_rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= nfc_pkg::ST_IDLE;
			op_q <= nfc_pkg::OP_READ_ARRAY;
			pins_q <= `NFC_PINS_IDLE;
			cnt_q <= '0;
			step_q <= '0;
			polling_q <= 1'b0;
			exiting_q <= 1'b0;
			addr_q <= '0;
			wd0_q <= '0;
			wd1_q <= '0;
			rd_q <= '0;
			dev_st_q <= '0;
			err_lock_q <= 1'b0;
			err_vpp_q <= 1'b0;
			err_prog_q <= 1'b0;
			otp_locked_q <= 1'b0;
			dual_en_q <= 1'b0;
			irq_st_q <= '0;
			mask_q <= '0;
			sw_rdata_q <= '0;
			irq_q <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			pins_q <= pins_d;
			cnt_q <= cnt_d;
			step_q <= step_d;
			polling_q <= polling_d;
			exiting_q <= exiting_d;
			addr_q <= addr_d;
			wd0_q <= wd0_d;
			wd1_q <= wd1_d;
			rd_q <= rd_d;
			dev_st_q <= dev_st_d;
			err_lock_q <= err_lock_d;
			err_vpp_q <= err_vpp_d;
			err_prog_q <= err_prog_d;
			otp_locked_q <= otp_locked_d;
			dual_en_q <= dual_en_d;
			irq_st_q <= irq_st_d;
			mask_q <= mask_d;
			sw_rdata_q <= sw_rdata_d;
			irq_q <= irq_d;
		end
	end

	assign flash_o = pins_q;
	assign sw_rdata = sw_rdata_q;
	assign irq = irq_q;

endmodule

`default_nettype wire

//--- tb/nfc_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module nfc_ctrl_checker #(
	parameter int ACC_CYC = 3,
	parameter int WP_CYC  = 2,
	parameter int WH_CYC  = 1
) (
	// clock and reset
	input wire logic               sys_clk,
	input wire logic               rst_b,
	// register port
	input wire logic [7:0]         sw_addr,
	input wire logic [31:0]        sw_wdata,
	input wire logic               sw_wr,
	input wire logic               sw_rd,
	input wire logic [31:0]        sw_rdata,
	input wire logic               irq,
	// flash pins
	input wire nfc_pkg::nfc_pins_t flash_o,
	input wire logic [15:0]        flash_dq_in
);
	logic [3:0] low_q;
	logic [3:0] low_d;
	always_comb begin
		low_d = (flash_o.we_n && flash_o.oe_n) ? 4'h0 : low_q + 4'h1;
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			low_q <= 4'h0;
		else
			low_q <= low_d;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_hold;
		flash_o.dq_oe && $stable(flash_o.dq_out) ##1
			(!flash_o.dq_oe || !flash_o.we_n);
	endsequence
	a_rdata_idle: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
		else $error("read data outside its slot");
	a_unmapped_zero: assert property (
		$past(sw_rd) && $past(sw_addr) == 8'hFC |-> sw_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_strobe_excl: assert property (!(!flash_o.we_n && !flash_o.oe_n))
		else $error("write and output enable together");
	a_ce_cover: assert property (
		!flash_o.we_n || !flash_o.oe_n |-> !flash_o.ce_n)
		else $error("strobe without chip select");
	a_we_len: assert property ($rose(flash_o.we_n) |-> low_q == WP_CYC)
		else $error("write pulse length wrong");
	a_oe_len: assert property ($rose(flash_o.oe_n) |-> low_q == ACC_CYC)
		else $error("read pulse length wrong");
	a_wr_hold: assert property ($rose(flash_o.we_n) |-> s_hold)
		else $error("write data hold wrong");
	a_rd_nodrive: assert property (!flash_o.oe_n |-> !flash_o.dq_oe)
		else $error("data driven during read");
	a_rd_addr: assert property (
		!flash_o.oe_n && !$past(flash_o.oe_n) |-> $stable(flash_o.addr))
		else $error("address moved during read");
endmodule
bind nfc_ctrl nfc_ctrl_checker #(
	.ACC_CYC(ACC_CYC), .WP_CYC(WP_CYC), .WH_CYC(WH_CYC)
) u_nfc_ctrl_checker (
	.sys_clk(sys_clk), .rst_b(rst_b), .sw_addr(sw_addr),
	.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
	.sw_rdata(sw_rdata), .irq(irq), .flash_o(flash_o),
	.flash_dq_in(flash_dq_in)
);
`default_nettype wire

//--- tb/nfc_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module nfc_flash_model (
	// controller pins
	input  wire nfc_pkg::nfc_pins_t pins,
	output logic [15:0]             dq,
	// result pattern {lock, vpp, fail}
	input  wire logic [2:0]         inj
);
	logic [7:0]  pend;
	logic [1:0]  mode;
	logic [2:0]  err;
	logic [1:0]  busy;
	logic        ulock;
	logic [15:0] last;
	logic [7:0]  c;
	logic [20:0] a;
	logic [15:0] drv;
	logic [20:0] mem_a;
	logic [15:0] mem_d;
	initial begin
		{pend, mode, err, busy, ulock, last, mem_d} = '0;
		mem_a = '1;
	end
	// code from low data byte, full address
	always @(posedge pins.we_n) begin
		c = pins.dq_out[7:0];
		a = pins.addr;
		if (pend == 8'hC0) begin
			if (a == 21'h000080 && pins.dq_out == 16'hFFFD)
				ulock = 1'b1;
			else if (a[20:8] != 0 || a[7:0] < 8'h81 || a[7:0] > 8'h88)
				err[0] = 1'b1;
			// vpp error blocks, else result pattern
			else if (!err[1])
				err = err | inj;
		end
		if (pend != 8'h00) begin
			// word program keeps the written word
			if (pend == 8'h40 || pend == 8'h10) begin
				mem_a = a;
				mem_d = pins.dq_out;
			end
			busy = 2'd2;
			mode = 2'd1;
			pend = (pend == 8'hE0) ? 8'hE1 : 8'h00;
		end else begin
			case (c)
				8'h40, 8'h10, 8'hC0, 8'hE0, 8'h20, 8'h60: pend = c;
				8'h50: err = 3'b000;
				8'hFF: mode = 2'd0;
				8'h90: mode = 2'd2;
				default: mode = 2'd1;
			endcase
		end
	end
	// status refreshed on each rising edge of oe_n
	always @(posedge pins.oe_n) begin
		last <= drv;
		if (busy != 0)
			busy <= busy - 2'd1;
	end
	// lock word; released bus shows inverted last value
	always @* begin
		if (mode == 2'd1)
			drv = {8'h00, busy == 0, 2'b00, err[0], err[1], 1'b0, err[2], 1'b0};
		else if (mode == 2'd2 && pins.addr[7:0] == 8'h80)
			drv = {14'h0000, ~ulock, 1'b0};
		else if (pins.addr == mem_a)
			drv = mem_d;
		else
			drv = {pins.addr[7:0], 8'h5A};
		dq = (pins.ce_n || pins.oe_n) ? ~last : drv;
	end
endmodule
`default_nettype wire

//--- tb/nor_flash_command_and_otp_programming_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module nor_flash_command_and_otp_programming_tb_top;
	logic               sys_clk;
	logic               rst_b;
	logic [7:0]         sw_addr;
	logic [31:0]        sw_wdata;
	logic               sw_wr;
	logic               sw_rd;
	logic [31:0]        sw_rdata;
	logic               irq;
	logic [15:0]        dq;
	logic [2:0]         inj;
	logic [31:0]        d;
	logic [2:0]         p;
	int                 err_count;
	int                 n_tests;
	nfc_pkg::nfc_pins_t pins;
	nfc_ctrl u_nfc_ctrl (.sys_clk(sys_clk), .rst_b(rst_b), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata(sw_rdata), .irq(irq), .flash_o(pins), .flash_dq_in(dq));
	nfc_flash_model u_nfc_flash_model (.pins(pins), .dq(dq), .inj(inj));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic wrap_up();
		if (err_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_wdata <= v;
		sw_wr <= 1'b1;
		@(posedge sys_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge sys_clk);
		sw_rd <= 1'b0;
		@(negedge sys_clk);
		d = sw_rdata;
	endtask
	task automatic op(input logic [4:0] code);
		wr(8'h00, {27'h0, code});
		repeat (300) begin
			rd(8'h14);
			if (d[8] === 1'b0)
				break;
		end
		chk({31'h0, d[8]}, 32'h0);
	endtask
	task automatic refused(input logic [4:0] code, input logic [31:0] exp);
		wr(8'h1C, 32'h7);
		op(code);
		rd(8'h1C);
		chk(d & 32'h4, exp);
	endtask
	initial begin
		#2000000;
		err_count++;
		wrap_up();
	end
	initial begin
		{rst_b, sw_addr, sw_wdata, sw_wr, sw_rd, inj} = '0;
		err_count = 0;
		n_tests = 0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(8'h14);
		chk(d, 32'h0);
		rd(8'hFC);
		chk(d, 32'h0);
		wr(8'h20, 32'h7);
		wr(8'h04, 32'h000142);
		wr(8'h08, 32'h0000BEEF);
		rd(8'h04);
		chk(d, 32'h142);
		op(5'd4);
		rd(8'h14);
		chk(d, 32'h80);
		chk({31'h0, irq}, 32'h1);
		wr(8'h1C, 32'h7);
		wr(8'h20, 32'h0);
		op(5'd1);
		rd(8'h10);
		chk(d, 32'hBEEF);
		chk({31'h0, irq}, 32'h0);
		wr(8'h20, 32'h7);
		rd(8'h14);
		chk({31'h0, irq}, 32'h1);
		op(5'd2);
		rd(8'h10);
		chk(d, 32'h80);
		for (int i = 6; i < 14; i++)
			refused(i[4:0], 32'h0);
		refused(5'd17, 32'h4);
		refused(5'd5, 32'h4);
		wr(8'h18, 32'h1);
		refused(5'd5, 32'h0);
		wr(8'h04, 32'h100085);
		refused(5'd14, 32'h4);
		wr(8'h04, 32'h000080);
		refused(5'd14, 32'h4);
		for (int i = 0; i < 3; i++) begin
			p = (i == 0) ? 3'b011 : (i == 1) ? 3'b001 : 3'b101;
			inj <= p;
			wr(8'h04, 32'h000085);
			refused(5'd14, 32'h0);
			rd(8'h14);
			chk(d, {20'h0, i == 1, i == 0, i == 2, 2'b01, 2'b00, p[0], p[1],
				1'b0, p[2], 1'b0});
			refused(5'd4, 32'h4);
			inj <= 3'b000;
			op(5'd3);
			rd(8'h14);
			chk(d & 32'hE00, 32'h0);
		end
		op(5'd16);
		rd(8'h14);
		chk(d & 32'h1000, 32'h0);
		op(5'd15);
		op(5'd16);
		rd(8'h14);
		chk(d & 32'h1000, 32'h1000);
		wr(8'h04, 32'h000086);
		refused(5'd14, 32'h4);
		wr(8'h04, 32'h000080);
		op(5'd0);
		op(5'd1);
		rd(8'h10);
		chk(d, 32'h805A);
		wr(8'h1C, 32'h7);
		rd(8'h1C);
		chk({31'h0, irq}, 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
